/* core/acbh_defs.vh */
// Constants for the converter control-byte host port.
// Assumes inclusion by the port module only; definitions only.
`ifndef ACBH_DEFS_VH
`define ACBH_DEFS_VH

// ==========================================================================
// Control byte field positions
`define ACBH_PWR_B1 7
`define ACBH_PWR_B0 6
`define ACBH_ACQ_SRC 5
`define ACBH_SPAN 4
`define ACBH_POLARITY 3
`define ACBH_CHAN_HI 2
`define ACBH_CHAN_LO 0

// ==========================================================================
// Reset values and mode codes
`define ACBH_CTRL_RESET 8'h00
`define ACBH_MODE_EXT_CLK 2'h0
`define ACBH_MODE_INT_CLK 2'h1
`define ACBH_MODE_STANDBY 2'h2
`define ACBH_MODE_DEEP 2'h3

// ==========================================================================
// Timing in conversion-clock cycles
`define ACBH_ACQ_CYCLES 6
`define ACBH_CONV_CYCLES 12
`define ACBH_MSB_INDEX 11
// MSB index and last acquisition count (cycles minus one) sized to the counters that load or compare them
`define ACBH_MSB_BIT 4'hB
`define ACBH_ACQ_LAST 3'h5

`endif

/* core/acbh_port.v */
// Control byte, acquisition/conversion sequencing and 8+4 read port of an
// eight-channel 12-bit successive-approximation converter.
// Assumes all pins synchronous to sys_clk; the analog side supplies the
// comparator decision and follows the trial code and track/hold outputs.
`include "acbh_defs.vh"

module acbh_port #(
    parameter INT_CLK_DIV = 26,
    parameter DIV_W = 8
) (
    input wire sys_clk,
    input wire nrst,
    input wire csN,
    input wire wrN,
    input wire rdN,
    input wire high_byte_select,
    input wire [7:0] busIn,
    input wire extConvClk,
    input wire sarCompare,
    output reg [7:0] busOut,
    output reg busOe,
    output reg doneN,
    output reg tracking,
    output reg [11:0] sarTrial,
    output reg [2:0] analog_inputs,
    output reg span_sel,
    output reg polarity_sel,
    output reg intClkMode,
    output reg standby_sleep,
    output reg deep_sleep
);

    // ======================================================================
    // States
    localparam ST_IDLE = 2'h0;
    localparam ST_ACQ_INT = 2'h1;
    localparam ST_ACQ_EXT = 2'h2;
    localparam ST_CONV = 2'h3;

    reg [1:0] state;
    reg [7:0] ctrl;
    reg [11:0] result;
    reg [3:0] bitIdx;
    reg [2:0] acqCount;
    reg [DIV_W-1:0] divCount;
    reg wrPrev;
    reg rdPrev;
    reg extClkPrev;
    reg intTick;
    reg [11:0] next_trial;
    reg [11:0] next_result;

    wire wrRise;
    wire rdStart;
    wire rdActive;
    wire convTick;
    wire [1:0] modeBits;
    wire [3:0] fillBits;

    // ======================================================================
    // Strobe qualification; chip select high masks both strobes
    assign wrRise = !csN && !wrPrev && wrN;
    assign rdActive = !csN && !rdN;
    assign rdStart = rdActive && rdPrev;
    assign modeBits = ctrl[`ACBH_PWR_B1:`ACBH_PWR_B0];
    assign fillBits = polarity_sel ? {4{result[`ACBH_MSB_INDEX]}} : 4'h0;

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wrPrev <= 1'b1;
            rdPrev <= 1'b1;
            extClkPrev <= 1'b0;
        end else begin
            wrPrev <= wrN | csN;
            rdPrev <= !rdActive;
            extClkPrev <= extConvClk;
        end
    end

    // ======================================================================
    // Conversion clock: rising edge of the external pin, or a divided tick
    // of sys_clk standing in for the on-chip oscillator
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            divCount <= {DIV_W{1'b0}};
            intTick <= 1'b0;
        end else if (divCount == INT_CLK_DIV[DIV_W-1:0] - 1'b1) begin
            divCount <= {DIV_W{1'b0}};
            intTick <= 1'b1;
        end else begin
            divCount <= divCount + 1'b1;
            intTick <= 1'b0;
        end
    end

    assign convTick = intClkMode ? intTick : (extConvClk && !extClkPrev);

    // ======================================================================
    // Next successive-approximation step; analog side compares offset code
    always @* begin
        next_trial = sarTrial;
        next_trial[bitIdx] = sarCompare;
        if (bitIdx != 4'h0) begin
            next_trial[bitIdx - 4'h1] = 1'b1;
        end
        // Offset binary becomes two's complement by flipping the top bit
        next_result = polarity_sel ? (next_trial ^ 12'h800) : next_trial;
    end

    // ======================================================================
    // Control byte and clock mode; power-down codes leave clock mode alone
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= `ACBH_CTRL_RESET;
            intClkMode <= 1'b0;
            analog_inputs <= 3'h0;
            span_sel <= 1'b0;
            polarity_sel <= 1'b0;
        end else if (wrRise) begin
            ctrl <= busIn;
            analog_inputs <= busIn[`ACBH_CHAN_HI:`ACBH_CHAN_LO];
            span_sel <= busIn[`ACBH_SPAN];
            polarity_sel <= busIn[`ACBH_POLARITY];
            if (!busIn[`ACBH_PWR_B1]) begin
                intClkMode <= busIn[`ACBH_PWR_B0];
            end
        end
    end

    // ======================================================================
    // Acquisition and conversion sequencer
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            acqCount <= 3'h0;
            bitIdx <= 4'h0;
            sarTrial <= 12'h000;
            result <= 12'h000;
            tracking <= 1'b0;
        end else if (wrRise) begin
            // Any write abandons what is running, except ACBH_ACQ_SRC low in ST_ACQ_EXT, which starts conversion
            acqCount <= 3'h0;
            if (state == ST_ACQ_EXT && !busIn[`ACBH_ACQ_SRC]) begin
                state <= ST_CONV;
                tracking <= 1'b0;
                bitIdx <= `ACBH_MSB_BIT;
                sarTrial <= 12'h800;
            end else if (busIn[`ACBH_ACQ_SRC]) begin
                state <= ST_ACQ_EXT;
                tracking <= 1'b1;
            end else begin
                state <= ST_ACQ_INT;
                tracking <= 1'b1;
            end
        end else begin
            case (state)
                ST_ACQ_INT: begin
                    if (convTick) begin
                        if (acqCount == `ACBH_ACQ_LAST) begin
                            state <= ST_CONV;
                            tracking <= 1'b0;
                            bitIdx <= `ACBH_MSB_BIT;
                            sarTrial <= 12'h800;
                        end else begin
                            acqCount <= acqCount + 3'h1;
                        end
                    end
                end
                ST_CONV: begin
                    // One decision per tick, MSB first: twelve ticks in all
                    if (convTick) begin
                        sarTrial <= next_trial;
                        if (bitIdx == 4'h0) begin
                            result <= next_result;
                            state <= ST_IDLE;
                        end else begin
                            bitIdx <= bitIdx - 4'h1;
                        end
                    end
                end
                ST_ACQ_EXT: begin
                    tracking <= 1'b1;
                end
                default: begin
                    tracking <= 1'b0;
                end
            endcase
        end
    end

    // ======================================================================
    // Done flag: completion wins over a read in the same cycle
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            doneN <= 1'b1;
        end else if (state == ST_CONV && convTick && bitIdx == 4'h0 && !wrRise) begin
            doneN <= 1'b0;
        end else if (wrRise || rdStart) begin
            doneN <= 1'b1;
        end
    end

    // ======================================================================
    // Power-down applies only once idle, so a running conversion finishes
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            standby_sleep <= 1'b0;
            deep_sleep <= 1'b0;
        end else begin
            standby_sleep <= state == ST_IDLE && !wrRise && modeBits == `ACBH_MODE_STANDBY;
            deep_sleep <= state == ST_IDLE && !wrRise && modeBits == `ACBH_MODE_DEEP;
        end
    end

    // ======================================================================
    // Read port; one cycle of latency, floats whenever chip select is high
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            busOe <= 1'b0;
            busOut <= 8'h00;
        end else begin
            busOe <= rdActive;
            if (high_byte_select) begin
                busOut <= {fillBits, result[11:8]};
            end else begin
                busOut <= result[7:0];
            end
        end
    end

endmodule // acbh_port

/* sim/acbh_port_monitor.sv */
// Assertion checker for the converter host port.
// Assumes binding to acbh_port; sees its ports only.
module acbh_port_monitor (
    input wire sys_clk,
    input wire nrst,
    input wire csN,
    input wire wrN,
    input wire rdN,
    input wire high_byte_select,
    input wire [7:0] busIn,
    input wire [7:0] busOut,
    input wire busOe,
    input wire doneN,
    input wire tracking,
    input wire [2:0] analog_inputs,
    input wire span_sel,
    input wire polarity_sel,
    input wire intClkMode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // ========================================
    // Write edge: strobe released while selected
    sequence s_wr;
        !csN && wrN && !$past(wrN) && !$past(csN);
    endsequence
    a_float_deselect: assert property (csN |=> !busOe) else $error("bus driven");
    a_read_drives: assert property (!csN && !rdN |=> busOe) else $error("no drive");
    a_fill_zero: assert property (!csN && !rdN && high_byte_select && !polarity_sel
        |=> busOut[7:4] == 4'h0) else $error("fill not zero");
    a_fill_sign: assert property (!csN && !rdN && high_byte_select && polarity_sel
        |=> busOut[7:4] == {4{busOut[3]}}) else $error("fill not sign");
    a_acq_start: assert property (s_wr ##0 busIn[5] |=> tracking && doneN)
        else $error("no acquisition");
    a_config_take: assert property (s_wr
        |=> {3'h0, span_sel, polarity_sel, analog_inputs} == ($past(busIn) & 8'h1F))
        else $error("config lost");
    a_int_mode: assert property (s_wr ##0 busIn[7:6] == 2'h1 |=> intClkMode)
        else $error("no int clock");
    a_pd_keeps: assert property (s_wr ##0 busIn[7] |=> intClkMode == $past(intClkMode))
        else $error("clock mode moved");
    a_conv_len: assert property ($fell(tracking) |-> doneN [*8]) else $error("short conv");
    a_reset_state: assert property (disable iff (1'b0) !nrst |=> doneN && !busOe && !intClkMode)
        else $error("bad reset state");
endmodule // acbh_port_monitor
bind acbh_port acbh_port_monitor u_mon (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .csN(csN),
    .wrN(wrN),
    .rdN(rdN),
    .high_byte_select(high_byte_select),
    .busIn(busIn),
    .busOut(busOut),
    .busOe(busOe),
    .doneN(doneN),
    .tracking(tracking),
    .analog_inputs(analog_inputs),
    .span_sel(span_sel),
    .polarity_sel(polarity_sel),
    .intClkMode(intClkMode)
);

/* sim/acbh_analog_model.sv */
// Analog side model: comparator judging the trial code.
// Assumes an offset-binary trial code; the bench sets the input.
module acbh_analog_model (
    input wire [11:0] sarTrial,
    input wire [11:0] target,
    output wire sarCompare
);
    timeunit 1ns;
    timeprecision 1ps;
    // Keep a trial bit while the trial does not pass the input
    assign sarCompare = (sarTrial <= target);
endmodule // acbh_analog_model

/* sim/adc_control_byte_host_port_tb.sv */
// Self-checking bench for the converter host port.
// Assumes acbh_port with a short internal clock divider.
module adc_control_byte_host_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, nrst = 0, csN = 1, wrN = 1, rdN = 1, high_byte_select = 0, eclk = 0;
    logic [7:0] busIn = 8'h00;
    logic [7:0] rb;
    logic [11:0] target = 12'hA5C;
    wire [7:0] busOut;
    wire [11:0] sarTrial;
    wire [2:0] analog_inputs;
    wire busOe, doneN, tracking, sarCompare, intClkMode, span_sel, polarity_sel, sbs, dps;
    int errors = 0, checked = 0, cnt;
    // ========================================
    // Clocks; external conversion clock is 4 cycles
    always #12.5 sys_clk = ~sys_clk;
    always #50 eclk = ~eclk;
    acbh_port #(.INT_CLK_DIV(2)) DUT (.sys_clk(sys_clk), .nrst(nrst), .csN(csN), .wrN(wrN),
        .rdN(rdN), .high_byte_select(high_byte_select), .busIn(busIn), .extConvClk(eclk),
        .sarCompare(sarCompare), .busOut(busOut), .busOe(busOe), .doneN(doneN),
        .tracking(tracking), .sarTrial(sarTrial), .analog_inputs(analog_inputs),
        .span_sel(span_sel), .polarity_sel(polarity_sel), .intClkMode(intClkMode),
        .standby_sleep(sbs), .deep_sleep(dps));
    acbh_analog_model u_ana (.sarTrial(sarTrial), .target(target), .sarCompare(sarCompare));
    task chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Host write; bus shows junk once released
    task wr(input logic [7:0] b);
        csN = 0; wrN = 0; busIn = b;
        @(negedge sys_clk) wrN = 1;
        @(negedge sys_clk) csN = 1;
        busIn = ~b;
        @(negedge sys_clk);
    endtask
    task rd(input logic h);
        csN = 0; rdN = 0; high_byte_select = h;
        repeat (2) @(negedge sys_clk);
        rb = busOut;
        csN = 1; rdN = 1;
        @(negedge sys_clk);
    endtask
    // Count cycles until hold (trk) or until done
    task waitFor(input bit trk);
        cnt = 0;
        while ((trk ? tracking === 1'b1 : doneN !== 1'b0) && cnt < 300) begin
            @(negedge sys_clk);
            cnt++;
        end
        // A wait that runs out is a hang, so it counts as a mismatch
        chk("timeout", cnt < 300, 1);
    endtask
    task t_ext_clock;
        wr(8'h15);
        chk("chan", analog_inputs, 5);
        chk("span", span_sel, 1);
        waitFor(1);
        chk("acq", cnt >= 17 && cnt <= 25, 1);
        waitFor(0);
        chk("conv", cnt >= 43 && cnt <= 50, 1);
        chk("trial", sarTrial, 12'hA5C);
        rd(1);
        chk("hi", rb, 8'h0A);
        chk("doneN", doneN, 1);
        rd(0);
        chk("lo", rb, 8'h5C);
    endtask
    task t_bipolar;
        target = 12'h35C;
        wr(8'h48);
        chk("int", intClkMode, 1);
        waitFor(0);
        rd(1);
        chk("hi", rb, 8'hFB);
        rd(0);
        chk("lo", rb, 8'h5C);
    endtask
    task t_ext_acq;
        wr(8'h60);
        repeat (80) @(negedge sys_clk);
        chk("track", {tracking, doneN}, 3);
        wr(8'h40);
        chk("hold", tracking, 0);
        waitFor(0);
        chk("conv", cnt >= 20 && cnt <= 28, 1);
    endtask
    task t_abort;
        wr(8'h40);
        repeat (16) @(negedge sys_clk);
        wr(8'h40);
        chk("restart", {tracking, doneN}, 3);
        waitFor(0);
        // Fresh six-tick acquisition plus twelve-tick conversion after the abort
        chk("reacq", cnt >= 33 && cnt <= 36, 1);
    endtask
    task t_power;
        wr(8'hC0);
        waitFor(0);
        // Sleep outputs follow the idle state one cycle after done
        @(negedge sys_clk);
        chk("deep", {dps, sbs, intClkMode}, 5);
        wr(8'h80);
        waitFor(0);
        @(negedge sys_clk);
        chk("stby", {dps, sbs, intClkMode}, 3);
        wr(8'h00);
        chk("ext", {dps, sbs, intClkMode}, 0);
        waitFor(0);
    endtask
    task t_deselect;
        rdN = 0; wrN = 0; busIn = 8'h07;
        @(negedge sys_clk) wrN = 1;
        repeat (2) @(negedge sys_clk);
        chk("float", {busOe, analog_inputs}, 0);
        rdN = 1;
    endtask
    task end_of_test;
        if (errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge sys_clk);
        nrst = 1;
        chk("rst", {intClkMode, doneN, busOe}, 2);
        t_ext_clock;
        t_bipolar;
        t_ext_acq;
        t_abort;
        t_power;
        t_deselect;
        end_of_test;
    end
    // Watchdog well past the expected run length
    initial begin
        #200000;
        errors++;
        end_of_test;
    end
endmodule // adc_control_byte_host_port_tb
